/* File: rtl/spr_pid_core.sv */
// one discrete pid step with output limiting
module spr_pid_core import spr_pkg::*; (
  // operands
  input wire spr_gains_s gains,
  input wire logic signed [DW-1:0] err,
  input wire logic signed [DW-1:0] err_prev,
  input wire logic [DW-1:0] integ,
  // limited output, tenths of percent
  output logic [DW-1:0] y_lim
);
  logic signed [79:0] ta;
  logic signed [79:0] ca;
  logic signed [79:0] cb;
  logic signed [79:0] d;
  logic signed [79:0] y;

  always_comb begin
    ta = (gains.ta == ZERO) ? 80'sd1 : signed'({64'h0, gains.ta});
    cb = signed'({64'h0, gains.kd}) * 80'(GAIN_ONE) / ta;
    ca = 80'(GAIN_ONE) + signed'({64'h0, gains.ki}) * ta / 80'(GAIN_ONE) + cb;
    d = ca * 80'(err) - cb * 80'(err_prev);
    y = signed'({64'h0, integ}) + signed'({64'h0, gains.kp}) * d / 80'(PID_DIV);
    if (y < 80'sd0) begin
      y_lim = ZERO;
    end else if (y > signed'({64'h0, OUT_MAX})) begin
      y_lim = OUT_MAX;
    end else begin
      y_lim = y[DW-1:0];
    end
  end
endmodule : spr_pid_core

/* File: rtl/spr_pkg.sv */
// package: register map, reset values, scaling and shared types of the pid regulator
package spr_pkg;
  localparam int DW = 16;
  localparam int AW = 5;

  // register word indices
  localparam logic [AW-1:0] A_VERSION = 5'h00;
  localparam logic [AW-1:0] A_CSP = 5'h01;
  localparam logic [AW-1:0] A_PRESET1 = 5'h02;
  localparam logic [AW-1:0] A_PRESET2 = 5'h03;
  localparam logic [AW-1:0] A_PRESET3 = 5'h04;
  localparam logic [AW-1:0] A_PRESET4 = 5'h05;
  localparam logic [AW-1:0] A_PV = 5'h06;
  localparam logic [AW-1:0] A_OUT = 5'h07;
  localparam logic [AW-1:0] A_MANUAL = 5'h08;
  localparam logic [AW-1:0] A_STATUS = 5'h09;
  localparam logic [AW-1:0] A_SRC = 5'h0a;
  localparam logic [AW-1:0] A_SMIN = 5'h0b;
  localparam logic [AW-1:0] A_SMAX = 5'h0c;
  localparam logic [AW-1:0] A_KP = 5'h0d;
  localparam logic [AW-1:0] A_KI = 5'h0e;
  localparam logic [AW-1:0] A_KD = 5'h0f;
  localparam logic [AW-1:0] A_TA = 5'h10;
  localparam logic [AW-1:0] A_MMIN = 5'h11;
  localparam logic [AW-1:0] A_MMAX = 5'h12;
  localparam logic [AW-1:0] A_CTRL = 5'h13;

  // reset values (hundredths for gains and setpoints, tenths for hz)
  localparam logic [DW-1:0] RST_KP = 16'h0064;
  localparam logic [DW-1:0] RST_KI = 16'h01f4;
  localparam logic [DW-1:0] RST_KD = 16'h0000;
  localparam logic [DW-1:0] RST_TA = 16'h000a;
  localparam logic [DW-1:0] RST_SP = 16'h00c8;
  localparam logic [DW-1:0] RST_MAN = 16'h0000;
  localparam logic [DW-1:0] RST_SRC = 16'h0000;
  localparam logic [DW-1:0] RST_SMIN = 16'h0000;
  localparam logic [DW-1:0] RST_SMAX = 16'h2710;
  localparam logic [DW-1:0] RST_MMIN = 16'h0000;
  localparam logic [DW-1:0] RST_MMAX = 16'h0258;
  localparam logic [DW-1:0] ZERO = 16'h0000;

  // scaling
  localparam logic [DW-1:0] OUT_MAX = 16'h03e8;
  localparam logic [DW-1:0] AIN_FULL = 16'h2710;
  localparam logic [DW-1:0] MAN_MAX = 16'h0fa0;
  localparam int GAIN_ONE = 100;
  localparam int PID_DIV = 10000;

  // setpoint sources
  localparam logic [DW-1:0] SRC_REG = 16'h0000;
  localparam logic [DW-1:0] SRC_AIN = 16'h0001;
  localparam logic [DW-1:0] SRC_EP = 16'h0003;
  localparam logic [DW-1:0] SRC_TWO = 16'h0004;
  localparam logic [DW-1:0] SRC_THREE = 16'h0005;
  localparam logic [DW-1:0] SRC_FOUR = 16'h0006;

  // status and control bits
  localparam int ST_SLEEP = 0;
  localparam int ST_AUTO = 1;
  localparam int ST_LOW_AL = 2;
  localparam int ST_LOW_FT = 3;
  localparam int ST_HIGH_AL = 4;
  localparam int ST_HIGH_FT = 5;
  localparam int ST_USED = 6;
  localparam int CTRL_REVERSE = 0;

  // sampling period unit is 0.01 s
  localparam int CLK_PERIOD_NS = 20;
  localparam int TA_UNIT_NS = 10000000;
  localparam int TA_UNIT_CYC = TA_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic pv_high_fault;
    logic pv_high_alarm;
    logic pv_low_fault;
    logic pv_low_alarm;
    logic sleep_alarm;
  } spr_events_s;

  typedef struct packed {
    logic [DW-1:0] kp;
    logic [DW-1:0] ki;
    logic [DW-1:0] kd;
    logic [DW-1:0] ta;
  } spr_gains_s;

  // lo + frac * (hi - lo) / full
  function automatic logic [DW-1:0] spr_scale(input logic [DW-1:0] frac,
      input logic [DW-1:0] full, input logic [DW-1:0] lo, input logic [DW-1:0] hi);
    logic signed [47:0] span;
    logic signed [47:0] res;
    span = 48'(signed'(hi)) - 48'(signed'(lo));
    res = (signed'({32'h0, frac}) * span) / signed'({32'h0, full}) + 48'(signed'(lo));
    return res[DW-1:0];
  endfunction : spr_scale
endpackage : spr_pkg

/* File: rtl/spr_regulator.sv */
// sampled pid regulator: registers, sample timer, pid state and status
// Notes on behaviour
// - output is integral plus scaled pid term
// - automatic output limited to 0.0 .. 100.0 percent, manual output to 0.0 .. 400.0 percent
// - error sign follows direct or reverse action
// - one update per sampling period, gains from registers
// - source zero uses setpoint register, else displays
// - sources 4..6 pick preset by select inputs
// - source 6 preset index from select_input_b, select_input_a
// - process value scaled from analog fraction
// - output percent maps onto motor speed span
// - manual mode copies manual value to output
// - status bit 0 shows sleep
// - status bit 1 shows automatic operation
// - status bit 2 shows low alarm
// - status bit 3 shows low fault
// - status bit 4 shows high alarm
// - status bit 5 shows high fault
// - status bits 6..15 zero, word read-only
// - read-only application version register
module spr_regulator import spr_pkg::*; #(
  parameter int TA_UNIT_CYCLES = TA_UNIT_CYC,
  parameter logic [DW-1:0] APP_VERSION = 16'h0064
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // process side
  input wire logic [DW-1:0] analog_input_one,
  input wire logic [DW-1:0] ext_setpoint,
  input wire logic select_input_a,
  input wire logic select_input_b,
  input wire logic auto_mode,
  input wire spr_events_s events,
  // results
  output logic [DW-1:0] regulator_output,
  output logic [DW-1:0] speed_reference,
  output logic sample_tick
);
  logic [DW-1:0] csp_r;
  logic [3:0][DW-1:0] preset_r;
  logic [DW-1:0] man_r;
  logic [DW-1:0] src_r;
  logic [DW-1:0] smin_r;
  logic [DW-1:0] smax_r;
  logic [DW-1:0] mmin_r;
  logic [DW-1:0] mmax_r;
  logic [DW-1:0] ctrl_r;
  spr_gains_s gains_r;
  logic [DW-1:0] pv_r;
  logic [DW-1:0] out_r;
  logic [DW-1:0] speed_r;
  logic [DW-1:0] stat_r;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] integ_r;
  logic signed [DW-1:0] err_prev_r;
  logic [31:0] unit_cnt_r;
  logic [DW-1:0] per_cnt_r;
  logic tick_r;
  logic [DW-1:0] auto_sp;
  logic [DW-1:0] y_lim;
  logic signed [DW-1:0] err_nxt;
  logic [DW-1:0] rdata_nxt;
  logic unit_end;
  logic per_end;
  logic [DW-1:0] ta_eff;

  assign regulator_output = out_r;
  assign speed_reference = speed_r;
  assign sample_tick = tick_r;
  assign reg_rdata = rdata_r;

  spr_sp_select u_sp_select (
    .src(src_r),
    .sel_a(select_input_a),
    .sel_b(select_input_b),
    .ext_sp(ext_setpoint),
    .csp(csp_r),
    .preset(preset_r),
    .auto_sp(auto_sp)
  );

  spr_pid_core u_pid_core (
    .gains(gains_r),
    .err(err_nxt),
    .err_prev(err_prev_r),
    .integ(integ_r),
    .y_lim(y_lim)
  );

  // software writes; read-only words ignore writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preset_r <= {4{RST_SP}};
      man_r <= RST_MAN;
      src_r <= RST_SRC;
      smin_r <= RST_SMIN;
      smax_r <= RST_SMAX;
      mmin_r <= RST_MMIN;
      mmax_r <= RST_MMAX;
      ctrl_r <= ZERO;
      gains_r <= '{kp: RST_KP, ki: RST_KI, kd: RST_KD, ta: RST_TA};
    end else if (reg_wr) begin
      case (reg_addr)
        A_PRESET1: preset_r[0] <= reg_wdata;
        A_PRESET2: preset_r[1] <= reg_wdata;
        A_PRESET3: preset_r[2] <= reg_wdata;
        A_PRESET4: preset_r[3] <= reg_wdata;
        A_MANUAL: man_r <= (reg_wdata > MAN_MAX) ? MAN_MAX : reg_wdata;
        A_SRC: src_r <= reg_wdata;
        A_SMIN: smin_r <= reg_wdata;
        A_SMAX: smax_r <= reg_wdata;
        A_MMIN: mmin_r <= reg_wdata;
        A_MMAX: mmax_r <= reg_wdata;
        A_CTRL: ctrl_r <= reg_wdata;
        A_KP: gains_r.kp <= reg_wdata;
        A_KI: gains_r.ki <= reg_wdata;
        A_KD: gains_r.kd <= reg_wdata;
        A_TA: gains_r.ta <= reg_wdata;
        default: ;
      endcase
    end
  end

  // control setpoint: writable only for source zero, else shows live setpoint
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      csp_r <= RST_SP;
    end else if (src_r != SRC_REG) begin
      csp_r <= auto_sp;
    end else if (reg_wr && reg_addr == A_CSP) begin
      csp_r <= reg_wdata;
    end
  end

  // process value scaling
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pv_r <= ZERO;
    end else begin
      pv_r <= spr_scale(analog_input_one, AIN_FULL, smin_r, smax_r);
    end
  end

  // sample timer: unit of 0.01 s, then periods of ta units
  assign ta_eff = (gains_r.ta == ZERO) ? 16'h0001 : gains_r.ta;
  assign unit_end = (unit_cnt_r == 32'(TA_UNIT_CYCLES - 1));
  assign per_end = unit_end && (per_cnt_r >= ta_eff - 16'h0001);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unit_cnt_r <= 32'h0;
      per_cnt_r <= ZERO;
      tick_r <= 1'b0;
    end else begin
      unit_cnt_r <= unit_end ? 32'h0 : unit_cnt_r + 32'h1;
      if (per_end) begin
        per_cnt_r <= ZERO;
      end else if (unit_end) begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
      tick_r <= per_end;
    end
  end

  // error with action sign
  always_comb begin
    if (ctrl_r[CTRL_REVERSE]) begin
      err_nxt = signed'(pv_r) - signed'(auto_sp);
    end else begin
      err_nxt = signed'(auto_sp) - signed'(pv_r);
    end
  end

  // regulator output: manual bypass, automatic once per sample
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= ZERO;
    end else if (!auto_mode) begin
      out_r <= man_r;
    end else if (tick_r) begin
      out_r <= y_lim;
    end
  end

  // pid memory for the next sample
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      integ_r <= ZERO;
      err_prev_r <= '0;
    end else if (tick_r) begin
      err_prev_r <= err_nxt;
      integ_r <= auto_mode ? y_lim : man_r;
    end
  end

  // speed reference from output percent
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      speed_r <= ZERO;
    end else begin
      speed_r <= spr_scale(out_r, OUT_MAX, mmin_r, mmax_r);
    end
  end

  // logic status word
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= ZERO;
    end else begin
      stat_r <= ZERO;
      stat_r[ST_SLEEP] <= events.sleep_alarm;
      stat_r[ST_AUTO] <= auto_mode;
      stat_r[ST_LOW_AL] <= events.pv_low_alarm;
      stat_r[ST_LOW_FT] <= events.pv_low_fault;
      stat_r[ST_HIGH_AL] <= events.pv_high_alarm;
      stat_r[ST_HIGH_FT] <= events.pv_high_fault;
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    case (reg_addr)
      A_VERSION: rdata_nxt = APP_VERSION;
      A_CSP: rdata_nxt = csp_r;
      A_PRESET1: rdata_nxt = preset_r[0];
      A_PRESET2: rdata_nxt = preset_r[1];
      A_PRESET3: rdata_nxt = preset_r[2];
      A_PRESET4: rdata_nxt = preset_r[3];
      A_PV: rdata_nxt = pv_r;
      A_OUT: rdata_nxt = out_r;
      A_MANUAL: rdata_nxt = man_r;
      A_STATUS: rdata_nxt = stat_r;
      A_SRC: rdata_nxt = src_r;
      A_SMIN: rdata_nxt = smin_r;
      A_SMAX: rdata_nxt = smax_r;
      A_KP: rdata_nxt = gains_r.kp;
      A_KI: rdata_nxt = gains_r.ki;
      A_KD: rdata_nxt = gains_r.kd;
      A_TA: rdata_nxt = gains_r.ta;
      A_MMIN: rdata_nxt = mmin_r;
      A_MMAX: rdata_nxt = mmax_r;
      A_CTRL: rdata_nxt = ctrl_r;
      default: rdata_nxt = ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= ZERO;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= ZERO;
    end
  end

  // checks
  sequence s_auto_sample;
    auto_mode && tick_r;
  endsequence

  sequence s_status_read;
    reg_rd && reg_addr == A_STATUS;
  endsequence

  a_out_limited: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_auto_sample |=> out_r <= OUT_MAX)
    else $error("automatic output above limit");

  a_out_equation: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_auto_sample |=> out_r == $past(y_lim))
    else $error("output not taken from pid step");

  a_out_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    auto_mode && !tick_r ##1 auto_mode |-> $stable(out_r))
    else $error("output changed between samples");

  a_manual_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !auto_mode |=> out_r == $past(man_r))
    else $error("manual value not on output");

  a_err_memory: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick_r |=> err_prev_r == $past(err_nxt)
      && integ_r == ($past(auto_mode) ? $past(y_lim) : $past(man_r)))
    else $error("pid memory not updated");

  a_err_sign: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ctrl_r[CTRL_REVERSE] |-> err_nxt == signed'(pv_r) - signed'(auto_sp))
    else $error("reverse error sign wrong");

  a_csp_display: assert property (@(posedge clk_sys) disable iff (!rst_b)
    src_r != SRC_REG ##1 src_r != SRC_REG |-> csp_r == $past(auto_sp))
    else $error("control setpoint not showing live setpoint");

  a_preset_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
    src_r == SRC_FOUR && select_input_a && select_input_b |-> auto_sp == preset_r[3])
    else $error("wrong preset for both inputs high");

  a_status_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_status_read ##1 1 |-> reg_rdata[ST_AUTO] == $past(stat_r[ST_AUTO]) && $past(auto_mode, 2)
      == $past(stat_r[ST_AUTO]))
    else $error("status mode bit wrong");

  a_status_faults: assert property (@(posedge clk_sys) disable iff (!rst_b)
    events.pv_low_fault |=> stat_r[ST_LOW_FT])
    else $error("low fault not reported");

  a_status_rsvd: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_status_read |=> reg_rdata[DW-1:ST_USED] == 10'h000)
    else $error("reserved status bits set");

  a_sample_gap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick_r |=> !tick_r)
    else $error("sample pulse longer than one cycle");

  a_status_sleep: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> stat_r[ST_SLEEP] == $past(events.sleep_alarm))
    else $error("sleep bit does not follow sleep state");

  a_status_low_alarm: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> stat_r[ST_LOW_AL] == $past(events.pv_low_alarm))
    else $error("low alarm bit does not follow alarm");

  a_status_high_alarm: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> stat_r[ST_HIGH_AL] == $past(events.pv_high_alarm))
    else $error("high alarm bit does not follow alarm");

  a_status_high_fault: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> stat_r[ST_HIGH_FT] == $past(events.pv_high_fault))
    else $error("high fault bit does not follow fault");

  a_version_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == A_VERSION |=> reg_rdata == APP_VERSION)
    else $error("version word read wrong");
endmodule : spr_regulator

/* File: rtl/spr_sp_select.sv */
// automatic setpoint source selection
module spr_sp_select import spr_pkg::*; (
  // source and inputs
  input wire logic [DW-1:0] src,
  input wire logic sel_a,
  input wire logic sel_b,
  input wire logic [DW-1:0] ext_sp,
  input wire logic [DW-1:0] csp,
  input wire logic [3:0][DW-1:0] preset,
  // result
  output logic [DW-1:0] auto_sp
);
  always_comb begin
    case (src)
      SRC_REG: auto_sp = csp;
      SRC_AIN, SRC_EP: auto_sp = ext_sp;
      SRC_TWO: auto_sp = sel_a ? preset[1] : preset[0];
      SRC_THREE: auto_sp = sel_b ? preset[2] : (sel_a ? preset[1] : preset[0]);
      SRC_FOUR: auto_sp = preset[{sel_b, sel_a}];
      default: auto_sp = csp;
    endcase
  end
endmodule : spr_sp_select

/* File: verif/spr_plant.sv */
// analog sensor and speed reference consumer beside the regulator
module spr_plant (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // level that the sensor should report, hundredths of percent
  input wire logic [15:0] level_set,
  // speed reference taken from the regulator
  input wire logic [15:0] speed_reference,
  // sensor output and speed reference seen by the consumer
  output logic [15:0] analog_input_one,
  output logic [15:0] speed_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // sensor conversion lags one cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      analog_input_one <= 16'h0000;
      speed_seen <= 16'h0000;
    end else begin
      analog_input_one <= level_set;
      speed_seen <= speed_reference;
    end
  end
endmodule : spr_plant

/* File: verif/spr_regulator_tb.sv */
// self-checking bench of the sampled pid regulator
module spr_regulator_tb import spr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [4:0] a; logic w; logic [15:0] d; logic [15:0] e;} spr_row_s;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic [DW-1:0] analog_input_one;
  logic [DW-1:0] ext_setpoint = '0;
  logic [DW-1:0] ain_set = '0;
  logic select_input_a = 1'b0;
  logic select_input_b = 1'b0;
  logic auto_mode = 1'b0;
  spr_events_s events = '0;
  logic [DW-1:0] regulator_output;
  logic [DW-1:0] speed_reference;
  logic sample_tick;
  logic [DW-1:0] speed_seen;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic [15:0] d;
  logic [5:0] ev;

  spr_row_s rows [15] = '{
    '{A_VERSION, 1'b0, 16'h0000, 16'h0064},
    '{A_VERSION, 1'b1, 16'h1234, 16'h0064},
    '{A_KP, 1'b0, 16'h0000, RST_KP},
    '{A_KI, 1'b0, 16'h0000, RST_KI},
    '{A_KD, 1'b0, 16'h0000, RST_KD},
    '{A_TA, 1'b0, 16'h0000, RST_TA},
    '{A_CSP, 1'b0, 16'h0000, RST_SP},
    '{A_PRESET4, 1'b0, 16'h0000, RST_SP},
    '{A_SMAX, 1'b0, 16'h0000, RST_SMAX},
    '{A_MMAX, 1'b0, 16'h0000, RST_MMAX},
    '{A_MANUAL, 1'b0, 16'h0000, RST_MAN},
    '{A_MANUAL, 1'b1, 16'h1000, MAN_MAX},
    '{A_STATUS, 1'b1, 16'hffff, 16'h0000},
    '{A_OUT, 1'b1, 16'h0123, MAN_MAX},
    '{5'h1f, 1'b0, 16'h0000, 16'h0000}
  };

  spr_regulator #(.TA_UNIT_CYCLES(4)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analog_input_one(analog_input_one), .ext_setpoint(ext_setpoint),
    .select_input_a(select_input_a), .select_input_b(select_input_b),
    .auto_mode(auto_mode), .events(events), .regulator_output(regulator_output),
    .speed_reference(speed_reference), .sample_tick(sample_tick)
  );

  spr_plant plant (
    .clk_sys(clk_sys), .rst_b(rst_b), .level_set(ain_set),
    .speed_reference(speed_reference), .analog_input_one(analog_input_one),
    .speed_seen(speed_seen)
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    // return on an edge so that callers drive their next inputs there
    @(posedge clk_sys);
  endtask : rd

  // returns with regulator_output of the sample settled, speed_reference one edge later; n counts edges after the first one up to the sample pulse
  task automatic wait_tick(output int k);
    k = 0;
    @(posedge clk_sys);
    #1;
    while (sample_tick !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 100) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      report_and_stop();
    end
    @(posedge clk_sys);
    #1;
  endtask : wait_tick

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    $display("register table done");
    // status bits follow events and mode
    for (int i = 0; i < 6; i++) begin
      ev = 6'h01 << i;
      @(posedge clk_sys);
      events <= ev[4:0];
      auto_mode <= ev[5];
      repeat (2) @(posedge clk_sys);
      rd(A_STATUS, d);
      chk(d, {10'h000, ev[4], ev[3], ev[2], ev[1], ev[5], ev[0]});
    end
    events <= '0;
    auto_mode <= 1'b0;
    $display("status done");
    for (int i = 0; i < 4; i++) wr(5'(A_PRESET1 + i), 16'(16'h0101 * (i + 1)));
    for (int s = 4; s < 7; s++) begin
      wr(A_SRC, 16'(s));
      for (int p = 0; p < 4; p++) begin
        if (s == 4 && p > 1) continue;
        select_input_a <= p[0];
        select_input_b <= p[1];
        wr(A_CSP, 16'h7777);
        rd(A_CSP, d);
        chk(d, 16'(16'h0101 * ((s == 5 && p == 3) ? 3 : p + 1)));
      end
    end
    ext_setpoint <= 16'h0555;
    wr(A_SRC, SRC_AIN);
    rd(A_CSP, d);
    chk(d, 16'h0555);
    wr(A_SRC, SRC_EP);
    rd(A_CSP, d);
    chk(d, 16'h0555);
    wr(A_SRC, SRC_REG);
    wr(A_CSP, 16'h00c8);
    rd(A_CSP, d);
    chk(d, 16'h00c8);
    $display("setpoint select done");
    wr(A_SMIN, 16'h03e8);
    wr(A_SMAX, 16'h0bb8);
    ain_set <= 16'h09c4;
    repeat (3) @(posedge clk_sys);
    rd(A_PV, d);
    chk(d, 16'h05dc);
    wr(A_SMIN, 16'h0000);
    wr(A_SMAX, 16'h2710);
    $display("process value done");
    // integral starts from zero after a manual sample with value zero
    wr(A_MANUAL, 16'h0000);
    ain_set <= 16'h0064;
    wait_tick(n);
    @(posedge clk_sys);
    auto_mode <= 1'b1;
    wait_tick(n);
    chk(regulator_output, 16'h0096);
    for (int k = 2; k < 8; k++) begin
      wait_tick(n);
      if (k == 2) chk(16'(n), 16'h0026);
      chk(regulator_output, 16'((150 * k > 1000) ? 1000 : 150 * k));
    end
    wr(A_CTRL, 16'h0001);
    for (int k = 1; k < 8; k++) begin
      wait_tick(n);
      chk(regulator_output, 16'((150 * k > 1000) ? 0 : 1000 - 150 * k));
      if (k == 1) begin
        @(posedge clk_sys);
        #1;
        chk(speed_reference, 16'h01fe);
        @(posedge clk_sys);
        #1;
        chk(speed_seen, 16'h01fe);
      end
    end
    rd(A_OUT, d);
    chk(d, 16'h0000);
    // previous error was negative under reverse action
    wr(A_KD, 16'h000a);
    wr(A_CTRL, 16'h0000);
    wait_tick(n);
    chk(regulator_output, 16'h015e);
    $display("pid done");
    @(posedge clk_sys);
    auto_mode <= 1'b0;
    wr(A_MANUAL, 16'h0123);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(regulator_output, 16'h0123);
    $display("manual done");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(regulator_output, 16'h0000);
    chk(speed_reference, 16'h0000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(A_KD, d);
    chk(d, RST_KD);
    $display("second reset done");
    report_and_stop();
  end
endmodule : spr_regulator_tb
